// ---- src/eeprom_pkg.sv ----
// Purpose: shared constants and types for the two-wire eeprom slave
// Assumes: mclk runs at 10 MHz
// Notes:   register offsets are byte addresses of 32-bit words
package eeprom_pkg;

  // ************************************************************
  // timing
  // ************************************************************
  localparam int CLK_PERIOD_NS = 100;
  localparam int PROG_TIME_MS  = 5;
  // longest time, so rounded down
  localparam int PROG_CYCLES   = PROG_TIME_MS * 1_000_000 / CLK_PERIOD_NS;

  // ************************************************************
  // array and protocol
  // ************************************************************
  localparam int         ADDR_W     = 17;
  localparam int         PAGE_BYTES = 256;
  localparam int         PAGES      = 512;
  localparam logic [3:0] DEV_TYPE   = 4'ha;
  localparam logic [3:0] BIT_ACK    = 4'h8;
  localparam logic [3:0] BIT_DONE   = 4'h9;

  // ************************************************************
  // register map
  // ************************************************************
  localparam logic [3:0]  REG_CTRL       = 4'h0;
  localparam logic [3:0]  REG_STATUS     = 4'h4;
  localparam logic [3:0]  REG_ADDR       = 4'h8;
  localparam int          CTRL_SWWP_BIT  = 0;
  localparam int          STAT_BUSY_BIT  = 0;
  localparam int          STAT_STBY_BIT  = 1;
  localparam int          STAT_WP_BIT    = 2;
  localparam logic [31:0] CTRL_RST       = 32'h0000_0000;

  // ************************************************************
  // types
  // ************************************************************
  typedef enum logic [6:0] {
    ST_IDLE = 7'h01,
    ST_DEV  = 7'h02,
    ST_AHI  = 7'h04,
    ST_ALO  = 7'h08,
    ST_WR   = 7'h10,
    ST_RD   = 7'h20,
    ST_WAIT = 7'h40
  } state_t;

  typedef struct packed {
    logic wp;
    logic cs_lo;
    logic cs_hi;
    logic sda;
    logic scl;
  } pins_t;

  typedef struct packed {
    logic start;
    logic stop;
    logic rise;
    logic fall;
  } bus_evt_t;

endpackage

// ---- src/eeprom_slave.sv ----
// Purpose: two-wire serial eeprom slave with avalon status port
// Assumes: pins are asynchronous to mclk; scl far slower than mclk
// Notes:   one-cycle waitrequest on every avalon access
//
// The placing of the registers and the Avalon-MM interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
module eeprom_slave
#(
  parameter int PROG_CYCLES = eeprom_pkg::PROG_CYCLES
)
(
  input  wire logic        mclk,
  input  wire logic        rst_b,
  input  wire logic        scl_in,
  input  wire logic        sda_in,
  output logic             sda_out,
  output logic             sda_oe,
  input  wire logic        chip_select_hi,
  input  wire logic        chip_select_lo,
  input  wire logic        wp,
  input  wire logic [3:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest
);
  import eeprom_pkg::*;

  // commit walk needs a full page before the timer ends
  if (PROG_CYCLES <= PAGE_BYTES)
  begin : g_chk
    $error("PROG_CYCLES must exceed one page");
  end

  // ************************************************************
  // pin synchronisers and bus events
  // ************************************************************
  pins_t    pin_m_q;
  pins_t    pin_s_q;
  logic     scl_p_q;
  logic     sda_p_q;
  bus_evt_t ev;
  logic     wp_eff;

  // two flops per pin; select pins rely on board pull-downs
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      pin_m_q <= '1;
      pin_s_q <= '1;
      scl_p_q <= 1'b1;
      sda_p_q <= 1'b1;
    end
    else
    begin
      pin_m_q <= {wp, chip_select_lo, chip_select_hi, sda_in, scl_in};
      pin_s_q <= pin_m_q;
      scl_p_q <= pin_s_q.scl;
      sda_p_q <= pin_s_q.sda;
    end
  end

  // edges of clock, data changes while clock high
  always_comb
  begin
    ev.rise  = pin_s_q.scl & ~scl_p_q;
    ev.fall  = ~pin_s_q.scl & scl_p_q;
    ev.start = pin_s_q.scl & scl_p_q & sda_p_q & ~pin_s_q.sda;
    ev.stop  = pin_s_q.scl & scl_p_q & ~sda_p_q & pin_s_q.sda;
  end

  // ************************************************************
  // protocol engine
  // ************************************************************
  logic [7:0]        mem [0:PAGES*PAGE_BYTES-1];
  logic [7:0]        pbuf [0:PAGE_BYTES-1];
  state_t            st_q, st_d;
  logic [3:0]        bit_q, bit_d;
  logic [7:0]        sh_q, sh_d;
  logic [7:0]        tx_q, tx_d;
  logic              oe_q, oe_d;
  logic [ADDR_W-1:0] addr_q, addr_d;
  logic [255:0]      mask_q, mask_d;
  logic              busy_q, busy_d;
  logic [31:0]       tmr_q, tmr_d;
  logic [31:0]       ctrl_q, ctrl_d;
  logic              buf_we;
  logic              prog_go;
  logic              match;
  logic [7:0]        mem_rd;
  logic              standby;

  assign wp_eff  = pin_s_q.wp | ctrl_q[CTRL_SWWP_BIT];
  assign mem_rd  = mem[addr_q];
  assign standby = (st_q == ST_IDLE) & ~busy_q;
  // device word check, refused while programming
  assign match   = (sh_q[7:4] == DEV_TYPE) && (sh_q[3] == pin_s_q.cs_hi)
                   && (sh_q[2] == pin_s_q.cs_lo) && !busy_q;

  // byte engine: bits in on rise, out after fall, msb first
  always_comb
  begin
    st_d    = st_q;
    bit_d   = bit_q;
    sh_d    = sh_q;
    tx_d    = tx_q;
    oe_d    = oe_q;
    addr_d  = addr_q;
    mask_d  = mask_q;
    buf_we  = 1'b0;
    prog_go = 1'b0;
    if (ev.start)
    begin
      st_d  = ST_DEV;
      bit_d = 4'h0;
      oe_d  = 1'b0;
    end
    else if (ev.stop)
    begin
      st_d    = ST_IDLE;
      bit_d   = 4'h0;
      oe_d    = 1'b0;
      // partial pages commit too; protection drops the commit
      prog_go = (st_q == ST_WR) && (|mask_q) && !wp_eff && !busy_q;
    end
    else if (ev.rise)
    begin
      if (bit_q != BIT_DONE)
      begin
        bit_d = bit_q + 4'h1;
        sh_d  = {sh_q[6:0], pin_s_q.sda};
      end
      // master answers high after a read byte: done reading
      if (bit_q == BIT_ACK && st_q == ST_RD && pin_s_q.sda)
      begin
        st_d = ST_WAIT;
      end
    end
    else if (ev.fall)
    begin
      if (bit_q == BIT_ACK)
      begin
        oe_d = 1'b1;
        unique case (st_q)
          ST_DEV:
          begin
            if (match)
            begin
              st_d = sh_q[0] ? ST_RD : ST_AHI;
              if (!sh_q[0])
              begin
                addr_d[ADDR_W-1] = sh_q[1];
              end
            end
            else
            begin
              oe_d = 1'b0;
              st_d = ST_WAIT;
            end
          end
          ST_AHI:
          begin
            addr_d[15:8] = sh_q;
            st_d         = ST_ALO;
          end
          ST_ALO:
          begin
            addr_d[7:0] = sh_q;
            mask_d      = '0;
            st_d        = ST_WR;
          end
          ST_WR:
          begin
            buf_we             = 1'b1;
            mask_d[addr_q[7:0]] = 1'b1;
            addr_d[7:0]        = addr_q[7:0] + 8'h01;
          end
          ST_RD:
          begin
            oe_d   = 1'b0; // master owns the ack bit
            addr_d = addr_q + 17'h0_0001;
          end
          ST_IDLE, ST_WAIT:
          begin
            oe_d = 1'b0;
          end
        endcase
      end
      else if (bit_q == BIT_DONE)
      begin
        bit_d = 4'h0;
        oe_d  = 1'b0;
        if (st_q == ST_RD)
        begin
          tx_d = mem_rd;
          oe_d = ~mem_rd[7];
        end
      end
      else if (st_q == ST_RD && bit_q != 4'h0)
      begin
        tx_d = {tx_q[6:0], 1'b0};
        oe_d = ~tx_q[6];
      end
    end
  end

  // engine registers
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      st_q   <= ST_IDLE;
      bit_q  <= 4'h0;
      sh_q   <= 8'h00;
      tx_q   <= 8'h00;
      oe_q   <= 1'b0;
      addr_q <= '0;
      mask_q <= '0;
    end
    else
    begin
      st_q   <= st_d;
      bit_q  <= bit_d;
      sh_q   <= sh_d;
      tx_q   <= tx_d;
      oe_q   <= oe_d;
      addr_q <= addr_d;
      mask_q <= mask_d;
    end
  end

  // pin only ever pulled low or released
  assign sda_out = 1'b0;
  assign sda_oe  = oe_q;

  // ************************************************************
  // self-timed programming
  // ************************************************************
  // timer runs on mclk alone; no scl needed to finish
  always_comb
  begin
    busy_d = busy_q;
    tmr_d  = tmr_q;
    if (prog_go)
    begin
      busy_d = 1'b1;
      tmr_d  = 32'h0000_0000;
    end
    else if (busy_q)
    begin
      if (tmr_q == 32'(PROG_CYCLES - 1))
      begin
        busy_d = 1'b0;
      end
      else
      begin
        tmr_d = tmr_q + 32'h0000_0001;
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      busy_q <= 1'b0;
      tmr_q  <= 32'h0000_0000;
    end
    else
    begin
      busy_q <= busy_d;
      tmr_q  <= tmr_d;
    end
  end

  // page buffer fill; array written one byte a cycle early in the cycle
  always_ff @(posedge mclk)
  begin
    if (buf_we)
    begin
      pbuf[addr_q[7:0]] <= sh_q;
    end
    if (busy_q && tmr_q < 32'(PAGE_BYTES) && mask_q[tmr_q[7:0]])
    begin
      mem[{addr_q[ADDR_W-1:8], tmr_q[7:0]}] <= pbuf[tmr_q[7:0]];
    end
  end

  // ************************************************************
  // avalon register slave
  // ************************************************************
  logic        ack_q, ack_d;
  logic [31:0] rdata_q, rdata_d;

  assign avs_waitrequest = (avs_read | avs_write) & ~ack_q;
  assign avs_readdata    = rdata_q;

  // read data captured in the wait cycle, write lands on the ack edge
  always_comb
  begin
    ack_d   = (avs_read | avs_write) & ~ack_q;
    ctrl_d  = ctrl_q;
    rdata_d = rdata_q;
    if (avs_read && !ack_q)
    begin
      rdata_d = 32'h0000_0000; // unmapped reads as zero
      unique case (avs_address)
        REG_CTRL:   rdata_d = ctrl_q;
        REG_STATUS:
        begin
          rdata_d[STAT_BUSY_BIT] = busy_q;
          rdata_d[STAT_STBY_BIT] = standby;
          rdata_d[STAT_WP_BIT]   = wp_eff;
        end
        REG_ADDR:   rdata_d = {15'h0000, addr_q};
        default:    rdata_d = 32'h0000_0000;
      endcase
    end
    if (avs_write && ack_q && avs_address == REG_CTRL)
    begin
      ctrl_d[CTRL_SWWP_BIT] = avs_writedata[CTRL_SWWP_BIT];
    end
  end

  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      ack_q   <= 1'b0;
      ctrl_q  <= CTRL_RST;
      rdata_q <= 32'h0000_0000;
    end
    else
    begin
      ack_q   <= ack_d;
      ctrl_q  <= ctrl_d;
      rdata_q <= rdata_d;
    end
  end

  // ************************************************************
  // checks
  // ************************************************************
  // busy window length counted apart from the timer, so a broken timer shows up
  logic [31:0] prog_len_q, prog_len_d;

  always_comb
  begin
    prog_len_d = busy_q ? (prog_len_q + 32'h0000_0001) : 32'h0000_0000;
  end

  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      prog_len_q <= 32'h0000_0000;
    end
    else
    begin
      prog_len_q <= prog_len_d;
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);

  a_oe_clock_low: assert property ($changed(oe_q) |-> !pin_s_q.scl)
    else $error("data pin moved while clock high");
  a_ack_ninth: assert property (ev.fall && !ev.start && !ev.stop && bit_q == BIT_ACK
    && (st_q inside {ST_AHI, ST_ALO, ST_WR}) |=> sda_oe)
    else $error("no ack after received word");
  a_busy_noack: assert property (ev.fall && bit_q == BIT_ACK && st_q == ST_DEV
    && busy_q |=> !sda_oe && st_q == ST_WAIT)
    else $error("address acked while programming");
  a_select_compare: assert property (ev.fall && bit_q == BIT_ACK && st_q == ST_DEV
    && sh_q[3:2] != {pin_s_q.cs_hi, pin_s_q.cs_lo} |=> !sda_oe)
    else $error("acked foreign select bits");
  a_protect_write: assert property (ev.stop && wp_eff && !busy_q |=> !busy_q)
    else $error("protected write started programming");
  a_page_wrap: assert property (ev.fall && !ev.start && !ev.stop && bit_q == BIT_ACK
    && st_q == ST_WR |=> addr_q[16:8] == $past(addr_q[16:8])
    && addr_q[7:0] == $past(addr_q[7:0]) + 8'h01)
    else $error("page write left its page");
  a_read_inc: assert property (ev.fall && !ev.start && !ev.stop && bit_q == BIT_ACK
    && st_q == ST_RD |=> addr_q == $past(addr_q) + 17'h0_0001)
    else $error("read address did not advance");
  a_start_dev: assert property (ev.start |=> st_q == ST_DEV && bit_q == 4'h0 && !sda_oe)
    else $error("start not taken");
  a_stop_idle: assert property (ev.stop |=> st_q == ST_IDLE ##1 (standby || busy_q))
    else $error("stop did not end transfer");
  a_prog_len: assert property ($fell(busy_q) |-> prog_len_q == 32'(PROG_CYCLES))
    else $error("programming cycle length wrong");
  a_prog_end: assert property ($fell(busy_q) |-> $past(tmr_q) == 32'(PROG_CYCLES - 1))
    else $error("programming ended at wrong count");
  a_msb_first: assert property (ev.rise && !ev.start && !ev.stop && bit_q != BIT_DONE
    |=> sh_q[0] == $past(pin_s_q.sda) && sh_q[7:1] == $past(sh_q[6:0]))
    else $error("bit not shifted in msb first");

  c_commit: cover property ($fell(busy_q));
  c_read_byte: cover property (ev.fall && bit_q == BIT_ACK && st_q == ST_RD);
  c_busy_poll: cover property (ev.fall && bit_q == BIT_ACK && st_q == ST_DEV && busy_q);

endmodule

// ---- bench/twi_master.sv ----
// Purpose: behavioural two-wire bus master for the eeprom bench
// Assumes: scl period of 8 mclk, 3 high and 5 low
// Notes:   sda_pull high pulls data low; scl stands high between frames
`timescale 1ns/1ps
module twi_master
(
  input  wire logic mclk,
  input  wire logic sda,
  output logic      scl,
  output logic      sda_pull
);
  int slow = 0; // extra low cycles for a slow master

  initial
  begin
    scl      = 1'b1;
    sda_pull = 1'b0;
  end

  task automatic w(input int n);
    repeat (n) @(posedge mclk);
  endtask

  // one bit; data only moves while scl is low, so no false start
  task automatic bit_x(input logic b, output logic r);
    sda_pull <= ~b;
    w(3 + slow);
    scl <= 1'b1;
    w(2);
    r = sda;
    w(1);
    scl <= 1'b0;
    w(2);
  endtask

  // also serves as repeated start after an ack bit
  task automatic start();
    sda_pull <= 1'b0;
    w(2);
    scl <= 1'b1;
    w(4);
    sda_pull <= 1'b1;
    w(4);
    scl <= 1'b0;
    w(2);
  endtask

  task automatic stop();
    sda_pull <= 1'b1;
    w(2);
    scl <= 1'b1;
    w(4);
    sda_pull <= 1'b0;
    w(4);
  endtask

  task automatic send(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--)
      bit_x(d[i], r);
    bit_x(1'b1, ack);
  endtask

  task automatic recv(input logic last, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--)
      bit_x(1'b1, d[i]);
    bit_x(last, r);
  endtask

  // nine idle clocks then a start clear any half-done transfer
  task automatic recover();
    logic r;
    repeat (9) bit_x(1'b1, r);
    start();
  endtask
endmodule

// ---- bench/tb.sv ----
// Purpose: self-checking bench for the two-wire eeprom slave
// Assumes: 10 MHz mclk, programming count cut to 300
// Notes:   memory is read only where it was written first
`timescale 1ns/1ps
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin num_errors++; \
  $display("[ERR] %0t got %h exp %h", $time, (a), (e)); end end
module tb;
  import eeprom_pkg::*;
  localparam int PROG = 300;
  logic        mclk, rst_b, scl, m_pull, sda_oe, sda_out, cs_hi, cs_lo, wp;
  logic        avs_read, avs_write, avs_waitrequest, ack, oe_prev;
  logic [3:0]  avs_address;
  logic [31:0] avs_writedata, avs_readdata, rd;
  logic [7:0]  b;
  int          num_errors = 0;
  int          cmp_count = 0;
  int          cyc = 0;
  int          t0;
  wire         sda = ~(sda_oe | m_pull); // pull-up unless someone pulls

  eeprom_slave #(.PROG_CYCLES(PROG)) u_dut (.mclk(mclk), .rst_b(rst_b), .scl_in(scl),
    .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe), .chip_select_hi(cs_hi),
    .chip_select_lo(cs_lo), .wp(wp), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest));
  twi_master u_mst (.mclk(mclk), .sda(sda), .scl(scl), .sda_pull(m_pull));

  initial
  begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end

  // hang guard; the whole run needs about 4000 cycles
  always @(posedge mclk)
  begin
    cyc++;
    if (cyc == 30000)
    begin
      num_errors++;
      test_done();
    end
  end

  // device may only move the data line while scl is low
  always @(posedge mclk)
  begin
    if (rst_b && sda_oe !== oe_prev)
    begin
      `CHK(scl, 1'b0)
      `CHK(sda_out, 1'b0)
    end
    oe_prev <= sda_oe;
  end

  // ************************************
  // access tasks
  // ************************************
  task automatic test_done();
    if (num_errors == 0 && cmp_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic av_rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge mclk);
    avs_address <= a;
    avs_read    <= 1'b1;
    do @(posedge mclk); while (avs_waitrequest !== 1'b0);
    d = avs_readdata;
    avs_read <= 1'b0;
  endtask

  task automatic av_wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge mclk);
    avs_address   <= a;
    avs_writedata <= d;
    avs_write     <= 1'b1;
    do @(posedge mclk); while (avs_waitrequest !== 1'b0);
    avs_write <= 1'b0;
  endtask

  function automatic logic [7:0] dev(input logic p, input logic rw);
    return {DEV_TYPE, 2'b10, p, rw};
  endfunction

  task automatic addr(input logic [16:0] a);
    u_mst.start();
    u_mst.send(dev(a[16], 1'b0), ack);
    `CHK(ack, 1'b0)
    u_mst.send(a[15:8], ack);
    `CHK(ack, 1'b0)
    u_mst.send(a[7:0], ack);
    `CHK(ack, 1'b0)
  endtask

  task automatic wr_mem(input logic [16:0] a, input logic [7:0] d[$]);
    addr(a);
    foreach (d[i])
    begin
      u_mst.send(d[i], ack);
      `CHK(ack, 1'b0)
    end
    u_mst.stop();
  endtask

  task automatic rd_mem(input logic [16:0] a, input logic [7:0] e[$]);
    addr(a);
    u_mst.start();
    u_mst.send(dev(a[16], 1'b1), ack);
    `CHK(ack, 1'b0)
    foreach (e[i])
    begin
      u_mst.recv(i == e.size() - 1, b);
      `CHK(b, e[i])
    end
    u_mst.stop();
  endtask

  task automatic wait_idle();
    do av_rd(REG_STATUS, rd); while (rd[STAT_BUSY_BIT] !== 1'b0);
  endtask

  // ************************************
  // tests
  // ************************************
  initial
  begin
    rst_b = 1'b0;
    cs_hi = 1'b1;
    cs_lo = 1'b0;
    wp = 1'b0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_address = 4'h0;
    avs_writedata = 32'h0000_0000;
    repeat (3) @(posedge mclk);
    rst_b <= 1'b1;
    repeat (3) @(posedge mclk);
    u_mst.recover();
    u_mst.stop();
    av_rd(REG_STATUS, rd);
    `CHK(rd, 32'h0000_0002)
    av_rd(4'hc, rd);
    `CHK(rd, 32'h0000_0000)
    av_wr(REG_CTRL, 32'h0000_0001);
    av_rd(REG_STATUS, rd);
    `CHK(rd, 32'h0000_0006)
    av_wr(REG_CTRL, 32'h0000_0000);
    // partial page across the page end, then poll while busy
    wr_mem(17'h1_00fe, '{8'h12, 8'h34, 8'h56});
    av_rd(REG_STATUS, rd);
    `CHK(rd[STAT_BUSY_BIT], 1'b1)
    av_rd(REG_ADDR, rd);
    `CHK(rd, 32'h0001_0001)
    u_mst.start();
    u_mst.send(dev(1'b0, 1'b0), ack);
    `CHK(ack, 1'b1)
    u_mst.stop();
    wait_idle();
    rd_mem(17'h1_00fe, '{8'h12, 8'h34});
    rd_mem(17'h1_0000, '{8'h56});
    av_rd(REG_STATUS, rd);
    `CHK(rd, 32'h0000_0002)
    // select pin no longer matches the word
    cs_lo <= 1'b1;
    u_mst.start();
    u_mst.send(dev(1'b0, 1'b0), ack);
    `CHK(ack, 1'b1)
    u_mst.stop();
    cs_lo <= 1'b0;
    // slow master, then time the programming cycle
    u_mst.slow = 3;
    wr_mem(17'h1_ffff, '{8'h3c});
    u_mst.slow = 0;
    t0 = cyc;
    wait_idle();
    `CHK((cyc - t0) inside {[PROG - 10 : PROG + 4]}, 1'b1)
    wr_mem(17'h0_0000, '{8'h77});
    wait_idle();
    wp <= 1'b1;
    wr_mem(17'h0_0000, '{8'h88});
    wait_idle();
    av_rd(REG_STATUS, rd);
    `CHK(rd, 32'h0000_0006)
    wp <= 1'b0;
    rd_mem(17'h1_ffff, '{8'h3c, 8'h77});
    av_rd(REG_ADDR, rd);
    `CHK(rd, 32'h0000_0001)
    test_done();
  end
endmodule
